// ---- fsp_defines.svh ----
// Constants for the flash self-programming controller: offsets, fields, patterns and timing.
`ifndef FSP_DEFINES_SVH
`define FSP_DEFINES_SVH

// Control/status register placement.
`define FSP_CSR_DATA_OFS 8'h57
`define FSP_IO_DELTA 8'h20
`define FSP_CSR_IO_OFS (`FSP_CSR_DATA_OFS - `FSP_IO_DELTA)
`define FSP_CSR_RESET 8'h00

// Control/status bit positions.
`define FSP_BIT_IE 7
`define FSP_BIT_BUSY 6
`define FSP_BIT_SIG 5
`define FSP_BIT_REEN 4
`define FSP_BIT_LOCK 3
`define FSP_BIT_WRITE 2
`define FSP_BIT_ERASE 1
`define FSP_BIT_EN 0

// Legal patterns in the low five bits.
`define FSP_PAT_REEN 5'h11
`define FSP_PAT_LOCK 5'h09
`define FSP_PAT_WRITE 5'h05
`define FSP_PAT_ERASE 5'h03
`define FSP_PAT_FILL 5'h01

// Command windows in CPU cycles.
`define FSP_WIN_STORE 4
`define FSP_WIN_LOAD 3

// Address geometry: 15-bit word address, 128-word pages.
`define FSP_ADDR_BITS 15
`define FSP_PAGE_WORDS 128
`define FSP_NO_READ_WHILE_WRITE_REGION_FIRST_PAGE 8'h70

// Boot section start word addresses by boot size fuse pair.
`define FSP_BOOT_START_11 15'h7E00
`define FSP_BOOT_START_10 15'h7C00
`define FSP_BOOT_START_01 15'h7800
`define FSP_BOOT_START_00 15'h7000

// Flash operation time, in nanoseconds, and the clock period.
`define FSP_PROG_MIN_NS 3700000
`define FSP_PROG_MAX_NS 4500000
`define FSP_CLK_PERIOD_NS 10
`define FSP_PROG_CYCLES ((`FSP_PROG_MIN_NS + `FSP_CLK_PERIOD_NS - 1) / `FSP_CLK_PERIOD_NS)

`endif

// ---- fsp_pkg.sv ----
// Types shared by the flash self-programming controller.
`default_nettype none
package fsp_pkg;
  typedef enum logic [2:0] {
    MODE_NONE, MODE_FILL, MODE_ERASE, MODE_WRITE, MODE_LOCK, MODE_REEN, MODE_SIG
  } fsp_mode_t;
  typedef enum logic [1:0] {
    ST_IDLE, ST_ARMED, ST_BUSY
  } fsp_state_t;
endpackage
`default_nettype wire

// ---- fsp_op_timer.sv ----
// Operation timer that stands in for the oscillator-timed flash erase and write duration.
`timescale 1ns/1ps
`default_nettype none
module fsp_op_timer #(
  parameter int unsigned CYCLES = 370000
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic start_in,
  output logic busy_out,
  output logic done_out
);
  localparam int W = $clog2(CYCLES + 1);
  logic [W-1:0] count;

  ////////////////////////////////////////////////////////////////////////////////
  // Count down from the load value; done pulses on the last busy cycle.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      count <= '0;
    end else if (start_in && count == '0) begin
      count <= W'(CYCLES);
    end else if (count != '0) begin
      count <= count - W'(1);
    end
  end

  assign busy_out = (count != '0);
  assign done_out = (count == W'(1));

  a_done_ends_busy: assert property (@(posedge clk_in) disable iff (reset_in)
    done_out |=> !busy_out) else $error("timer still busy after done");
endmodule
`default_nettype wire

// ---- fsp_page_buffer.sv ----
// Temporary page buffer: one page of words with a loaded mask and a discard input.
`timescale 1ns/1ps
`default_nettype none
module fsp_page_buffer #(
  parameter int WORDS = 128,
  parameter int WIDTH = 16
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic wr_in,
  input wire logic [$clog2(WORDS)-1:0] wr_index_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic discard_in,
  input wire logic [$clog2(WORDS)-1:0] rd_index_in,
  output logic [WIDTH-1:0] rd_data_out,
  output logic loaded_out
);
  logic [WIDTH-1:0] mem [WORDS];
  logic [WORDS-1:0] valid;

  ////////////////////////////////////////////////////////////////////////////////
  // Storage has no reset; the valid mask alone says what was loaded.
  always_ff @(posedge clk_in) begin
    if (wr_in) begin
      mem[wr_index_in] <= wr_data_in;
    end
  end

  // Discard beats a load in the same cycle, so an aborted fill leaves nothing.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      valid <= '0;
    end else if (discard_in) begin
      valid <= '0;
    end else if (wr_in) begin
      valid[wr_index_in] <= 1'b1;
    end
  end

  // Unloaded words read as erased flash.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rd_data_out <= '1;
    end else begin
      rd_data_out <= valid[rd_index_in] ? mem[rd_index_in] : '1;
    end
  end

  assign loaded_out = |valid;

  a_discard_empties: assert property (@(posedge clk_in) disable iff (reset_in)
    discard_in |=> !loaded_out) else $error("buffer not empty after discard");
endmodule
`default_nettype wire

// ---- fsp_ctrl.sv ----
// Flash self-programming controller: control/status register, command windows and operation sequencing.
`timescale 1ns/1ps
`default_nettype none
`include "fsp_defines.svh"
module fsp_ctrl #(
  parameter int unsigned PROG_CYCLES = `FSP_PROG_CYCLES,
  parameter int PAGE_WORDS = `FSP_PAGE_WORDS
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_io_space_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic store_in,
  input wire logic load_in,
  input wire logic [15:0] pointer_in,
  input wire logic [7:0] r0_in,
  input wire logic [7:0] r1_in,
  output logic load_taken_out,
  output logic [7:0] load_data_out,
  input wire logic [7:0] signature_byte_in,
  input wire logic [7:0] lock_bits_in,
  input wire logic [7:0] fuse_low_in,
  input wire logic [7:0] fuse_high_in,
  input wire logic [7:0] fuse_ext_in,
  input wire logic [1:0] boot_size_fuse_in,
  input wire logic global_int_in,
  output logic irq_out,
  output logic cpu_stall_out,
  output logic rww_read_block_out,
  output logic [`FSP_ADDR_BITS-1:0] boot_start_out,
  output logic flash_erase_out,
  output logic flash_write_out,
  output logic flash_lock_write_out,
  output logic [7:0] lock_data_out,
  output logic [7:0] page_select_field_out,
  output logic flash_busy_out,
  input wire logic [$clog2(PAGE_WORDS)-1:0] flash_rd_index_in,
  output logic [15:0] flash_rd_word_out
);
  localparam int WI = $clog2(PAGE_WORDS);
  localparam logic [2:0] WIN_STORE_LAST = 3'(`FSP_WIN_STORE - 1);
  localparam logic [2:0] WIN_LOAD_LAST = 3'(`FSP_WIN_LOAD - 1);

  fsp_pkg::fsp_state_t state;
  fsp_pkg::fsp_mode_t mode;
  logic ready_interrupt_enable;
  logic section_busy_flag;
  logic [2:0] age;
  logic stall_op;
  logic reset_seen;
  logic csr_hit_wr;
  logic csr_hit_rd;
  logic store_take;
  logic load_take;
  logic expire;
  logic timer_start;
  logic timer_busy;
  logic timer_done;
  logic buf_wr;
  logic buf_discard;
  logic buf_loaded;
  logic target_rww;
  logic [4:0] cmd_low;
  logic [7:0] csr_value;
  fsp_pkg::fsp_mode_t next_mode;

  ////////////////////////////////////////////////////////////////////////////////
  // Register decode: one register seen from both address views.
  assign csr_hit_wr = reg_wr_in &&
                      (reg_io_space_in ? reg_addr_in == `FSP_CSR_IO_OFS : reg_addr_in == `FSP_CSR_DATA_OFS);
  assign csr_hit_rd = reg_rd_in &&
                      (reg_io_space_in ? reg_addr_in == `FSP_CSR_IO_OFS : reg_addr_in == `FSP_CSR_DATA_OFS);
  assign cmd_low = reg_wdata_in[4:0];

  // Decode the written pattern; anything not listed leaves the command state alone.
  always_comb begin
    next_mode = fsp_pkg::MODE_NONE;
    case (cmd_low)
      `FSP_PAT_REEN: next_mode = fsp_pkg::MODE_REEN;
      `FSP_PAT_LOCK: next_mode = fsp_pkg::MODE_LOCK;
      `FSP_PAT_WRITE: next_mode = fsp_pkg::MODE_WRITE;
      `FSP_PAT_ERASE: next_mode = fsp_pkg::MODE_ERASE;
      `FSP_PAT_FILL: begin
        next_mode = reg_wdata_in[`FSP_BIT_SIG] ? fsp_pkg::MODE_SIG : fsp_pkg::MODE_FILL;
      end
      default: next_mode = fsp_pkg::MODE_NONE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Instruction acceptance inside the open window.
  assign store_take = (state == fsp_pkg::ST_ARMED) && store_in && (mode != fsp_pkg::MODE_SIG);
  assign load_take = (state == fsp_pkg::ST_ARMED) && load_in &&
                     (mode == fsp_pkg::MODE_SIG || mode == fsp_pkg::MODE_LOCK) &&
                     (age <= WIN_LOAD_LAST);
  // The signature window is the load window; all others close on the store window.
  assign expire = (state == fsp_pkg::ST_ARMED) &&
                  ((mode == fsp_pkg::MODE_SIG) ? (age == WIN_LOAD_LAST && !load_in)
                                               : (age == WIN_STORE_LAST && !store_take));

  // Pages below the first no-read-while-write page lie in the read-while-write region.
  assign target_rww = pointer_in[15:8] < `FSP_NO_READ_WHILE_WRITE_REGION_FIRST_PAGE;

  assign timer_start = store_take &&
                       (mode == fsp_pkg::MODE_ERASE || mode == fsp_pkg::MODE_WRITE ||
                        mode == fsp_pkg::MODE_LOCK);
  assign buf_wr = store_take && (mode == fsp_pkg::MODE_FILL);
  // Re-enable written over a part-filled buffer throws the fill away; a finished page write also empties it.
  assign buf_discard = (csr_hit_wr && state == fsp_pkg::ST_IDLE && next_mode == fsp_pkg::MODE_REEN &&
                        buf_loaded) ||
                       (timer_done && mode == fsp_pkg::MODE_WRITE);

  ////////////////////////////////////////////////////////////////////////////////
  // Command state: idle, armed window, or running a timed operation.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state <= fsp_pkg::ST_IDLE;
      mode <= fsp_pkg::MODE_NONE;
    end else begin
      case (state)
        fsp_pkg::ST_IDLE: begin
          if (csr_hit_wr && next_mode != fsp_pkg::MODE_NONE) begin
            state <= fsp_pkg::ST_ARMED;
            mode <= next_mode;
          end
        end
        fsp_pkg::ST_ARMED: begin
          if (timer_start) begin
            state <= fsp_pkg::ST_BUSY;
          end else if (store_take || load_take || expire) begin
            state <= fsp_pkg::ST_IDLE;
            mode <= fsp_pkg::MODE_NONE;
          end
        end
        fsp_pkg::ST_BUSY: begin
          // Writes to the command bits are ignored until the operation ends.
          if (timer_done) begin
            state <= fsp_pkg::ST_IDLE;
            mode <= fsp_pkg::MODE_NONE;
          end
        end
        default: begin
          state <= fsp_pkg::ST_IDLE;
          mode <= fsp_pkg::MODE_NONE;
        end
      endcase
    end
  end

  // Cycles since the arming write; the window is counted from the cycle after it.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      age <= 3'h0;
    end else if (state == fsp_pkg::ST_IDLE) begin
      age <= 3'h0;
    end else if (state == fsp_pkg::ST_ARMED && age != 3'h7) begin
      age <= age + 3'h1;
    end
  end

  // Interrupt enable is plain software storage, written regardless of the pattern.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      ready_interrupt_enable <= 1'b0;
    end else if (csr_hit_wr) begin
      ready_interrupt_enable <= reg_wdata_in[`FSP_BIT_IE];
    end
  end

  // Section busy: set by an erase or page write aimed at the read-while-write region.
  // Set wins over clear; a refused re-enable leaves it standing.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      section_busy_flag <= 1'b0;
    end else if (timer_start && mode != fsp_pkg::MODE_LOCK && target_rww) begin
      section_busy_flag <= 1'b1;
    end else if (buf_wr) begin
      section_busy_flag <= 1'b0;
    end else if (store_take && mode == fsp_pkg::MODE_REEN && !timer_busy) begin
      section_busy_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Flash-side command strobes and latched operands.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      flash_erase_out <= 1'b0;
      flash_write_out <= 1'b0;
      flash_lock_write_out <= 1'b0;
    end else begin
      flash_erase_out <= timer_start && mode == fsp_pkg::MODE_ERASE;
      flash_write_out <= timer_start && mode == fsp_pkg::MODE_WRITE;
      flash_lock_write_out <= timer_start && mode == fsp_pkg::MODE_LOCK;
    end
  end

  // Page from the upper pointer byte; R1:R0 are ignored by erase and write, R1 by lock set.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      page_select_field_out <= 8'h00;
      lock_data_out <= 8'hFF;
      stall_op <= 1'b0;
    end else if (timer_start) begin
      if (mode == fsp_pkg::MODE_LOCK) begin
        lock_data_out <= r0_in;
        stall_op <= 1'b0;
      end else begin
        page_select_field_out <= pointer_in[15:8];
        stall_op <= !target_rww;
      end
    end
  end

  // Stall stands for the whole of an operation on the region the CPU runs from.
  assign cpu_stall_out = stall_op && timer_busy;
  assign rww_read_block_out = section_busy_flag;
  assign flash_busy_out = timer_busy;

  ////////////////////////////////////////////////////////////////////////////////
  // Load answers: signature row, or lock and fuse bytes picked by the pointer.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      load_taken_out <= 1'b0;
      load_data_out <= 8'h00;
    end else begin
      load_taken_out <= load_take;
      if (load_take) begin
        if (mode == fsp_pkg::MODE_SIG) begin
          load_data_out <= signature_byte_in;
        end else begin
          case (pointer_in[1:0])
            2'h0: load_data_out <= fuse_low_in;
            2'h1: load_data_out <= lock_bits_in;
            2'h2: load_data_out <= fuse_ext_in;
            default: load_data_out <= fuse_high_in;
          endcase
        end
      end
    end
  end

  // Register read view; command bits follow the live state so they clear together.
  always_comb begin
    csr_value = `FSP_CSR_RESET;
    csr_value[`FSP_BIT_IE] = ready_interrupt_enable;
    csr_value[`FSP_BIT_BUSY] = section_busy_flag;
    csr_value[`FSP_BIT_SIG] = mode == fsp_pkg::MODE_SIG;
    csr_value[`FSP_BIT_REEN] = mode == fsp_pkg::MODE_REEN;
    csr_value[`FSP_BIT_LOCK] = mode == fsp_pkg::MODE_LOCK;
    csr_value[`FSP_BIT_WRITE] = mode == fsp_pkg::MODE_WRITE;
    csr_value[`FSP_BIT_ERASE] = mode == fsp_pkg::MODE_ERASE;
    csr_value[`FSP_BIT_EN] = state != fsp_pkg::ST_IDLE;
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      reg_rdata_out <= `FSP_CSR_RESET;
    end else if (csr_hit_rd) begin
      reg_rdata_out <= csr_value;
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

  // Ready interrupt is a level, held while no command is pending.
  assign irq_out = ready_interrupt_enable && global_int_in && state == fsp_pkg::ST_IDLE;

  ////////////////////////////////////////////////////////////////////////////////
  // Boot size is a strap: caught once, one clock after reset release.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      reset_seen <= 1'b0;
      boot_start_out <= `FSP_BOOT_START_11;
    end else if (!reset_seen) begin
      reset_seen <= 1'b1;
      case (boot_size_fuse_in)
        2'b11: boot_start_out <= `FSP_BOOT_START_11;
        2'b10: boot_start_out <= `FSP_BOOT_START_10;
        2'b01: boot_start_out <= `FSP_BOOT_START_01;
        default: boot_start_out <= `FSP_BOOT_START_00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Buffer word from pointer bits 7:1; bit 0 is dropped for stores.
  fsp_page_buffer #(
    .WORDS(PAGE_WORDS),
    .WIDTH(16)
  ) u_buffer (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .wr_in(buf_wr),
    .wr_index_in(pointer_in[WI:1]),
    .wr_data_in({r1_in, r0_in}),
    .discard_in(buf_discard),
    .rd_index_in(flash_rd_index_in),
    .rd_data_out(flash_rd_word_out),
    .loaded_out(buf_loaded)
  );

  fsp_op_timer #(
    .CYCLES(PROG_CYCLES)
  ) u_timer (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .start_in(timer_start),
    .busy_out(timer_busy),
    .done_out(timer_done)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  a_irq_gated_enable: assert property (@(posedge clk_in) disable iff (reset_in)
    (state != fsp_pkg::ST_IDLE) |-> !irq_out) else $error("interrupt while enable set");
  a_window_expiry: assert property (@(posedge clk_in) disable iff (reset_in)
    (state == fsp_pkg::ST_ARMED && mode != fsp_pkg::MODE_SIG && age == WIN_STORE_LAST && !store_in)
    |=> (csr_value[4:0] == 5'h00)) else $error("command bits survive window");
  a_sig_expiry: assert property (@(posedge clk_in) disable iff (reset_in)
    (state == fsp_pkg::ST_ARMED && mode == fsp_pkg::MODE_SIG && age == WIN_LOAD_LAST && !load_in)
    |=> !csr_value[`FSP_BIT_EN] && !csr_value[`FSP_BIT_SIG]) else $error("signature bits stuck");
  a_busy_on_rww: assert property (@(posedge clk_in) disable iff (reset_in)
    (timer_start && mode != fsp_pkg::MODE_LOCK && target_rww) |=> section_busy_flag && timer_busy)
    else $error("busy flag not set");
  a_stall_no_read_while_write_region: assert property (@(posedge clk_in) disable iff (reset_in)
    (timer_start && mode != fsp_pkg::MODE_LOCK && !target_rww) |=> cpu_stall_out [*2])
    else $error("no stall for boot region");
  a_enable_held: assert property (@(posedge clk_in) disable iff (reset_in)
    (state == fsp_pkg::ST_BUSY && !timer_done) |=> csr_value[`FSP_BIT_EN]) else $error("enable dropped");
  a_reen_refused: assert property (@(posedge clk_in) disable iff (reset_in)
    (section_busy_flag && timer_busy && !buf_wr) |=> section_busy_flag) else $error("busy cleared early");
  a_fill_clears_busy: assert property (@(posedge clk_in) disable iff (reset_in)
    buf_wr |=> !section_busy_flag && state == fsp_pkg::ST_IDLE) else $error("fill left busy");
  a_load_answer: assert property (@(posedge clk_in) disable iff (reset_in)
    (state == fsp_pkg::ST_ARMED && mode == fsp_pkg::MODE_LOCK && load_in && age <= WIN_LOAD_LAST)
    |=> load_taken_out) else $error("lock load not answered");
  a_bad_pattern: assert property (@(posedge clk_in) disable iff (reset_in)
    (csr_hit_wr && state == fsp_pkg::ST_IDLE && next_mode == fsp_pkg::MODE_NONE)
    |=> state == fsp_pkg::ST_IDLE) else $error("illegal pattern acted");
endmodule
`default_nettype wire

// ---- fsp_cpu_model.sv ----
// CPU core model that issues store and load program-memory instructions.
`timescale 1ns/1ps
`default_nettype none
module fsp_cpu_model (
  input wire logic clk_in,
  output logic store_out,
  output logic load_out,
  output logic [15:0] pointer_out,
  output logic [7:0] r0_out,
  output logic [7:0] r1_out
);
  // Idle values until the first instruction.
  initial begin
    store_out = 1'b0;
    load_out = 1'b0;
    pointer_out = 16'h0000;
    {r1_out, r0_out} = 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One store; operands are inverted afterwards so that nothing stale looks valid.
  task automatic spm(input logic [15:0] ptr, input logic [15:0] data);
    @(posedge clk_in);
    store_out <= 1'b1;
    pointer_out <= {ptr[15:1], 1'b0};
    {r1_out, r0_out} <= data;
    @(posedge clk_in);
    store_out <= 1'b0;
    pointer_out <= ~{ptr[15:1], 1'b0};
    {r1_out, r0_out} <= ~data;
  endtask

  // One load; the pointer keeps its low bit because it selects the byte.
  task automatic lpm(input logic [15:0] ptr);
    @(posedge clk_in);
    load_out <= 1'b1;
    pointer_out <= ptr;
    @(posedge clk_in);
    load_out <= 1'b0;
    pointer_out <= ~ptr;
  endtask
endmodule
`default_nettype wire

// ---- flash_self_program_ctrl_tb.sv ----
// Self-checking testbench for the flash self-programming controller.
`timescale 1ns/1ps
`default_nettype none
`include "fsp_defines.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module flash_self_program_ctrl_tb;
  localparam logic [7:0] SIG = 8'hA5, LOCKB = 8'hC3, FL = 8'h62, FH = 8'hD9, FE = 8'hFD;
  logic clk_in, reset_in, reg_io_space_in, reg_wr_in, reg_rd_in, global_int_in;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, load_data_out, lock_data_out, page_select_field_out;
  logic [1:0] boot_size_fuse_in;
  logic [6:0] flash_rd_index_in;
  logic [14:0] boot_start_out;
  logic [15:0] flash_rd_word_out;
  logic load_taken_out, irq_out, cpu_stall_out, rww_read_block_out, flash_erase_out, flash_write_out;
  logic flash_lock_write_out, flash_busy_out;
  wire logic store_in, load_in;
  wire logic [15:0] pointer_in;
  wire logic [7:0] r0_in, r1_in;
  logic [14:0] boot_exp [4] = '{15'h7000, 15'h7800, 15'h7C00, 15'h7E00};
  logic [7:0] rd_exp [4] = '{FL, LOCKB, FE, FH};
  int miscompares = 0;
  int n_tests = 0;

  fsp_ctrl #(.PROG_CYCLES(20), .PAGE_WORDS(128)) DUT (.clk_in, .reset_in, .reg_addr_in, .reg_io_space_in,
    .reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out, .store_in, .load_in, .pointer_in, .r0_in, .r1_in,
    .load_taken_out, .load_data_out, .signature_byte_in(SIG), .lock_bits_in(LOCKB), .fuse_low_in(FL),
    .fuse_high_in(FH), .fuse_ext_in(FE), .boot_size_fuse_in, .global_int_in, .irq_out, .cpu_stall_out,
    .rww_read_block_out, .boot_start_out, .flash_erase_out, .flash_write_out, .flash_lock_write_out,
    .lock_data_out, .page_select_field_out, .flash_busy_out, .flash_rd_index_in, .flash_rd_word_out);
  fsp_cpu_model cpu (.clk_in, .store_out(store_in), .load_out(load_in), .pointer_out(pointer_in),
    .r0_out(r0_in), .r1_out(r1_in));

  // Free-running 100 MHz clock.
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes always use the data view.
  task automatic reg_wr(input logic [7:0] d);
    @(posedge clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= `FSP_CSR_DATA_OFS;
    reg_io_space_in <= 1'b0;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    reg_wdata_in <= ~d;
  endtask

  // Read strobe, then the answer stands for the following cycle.
  task automatic check_csr(input logic [7:0] a, input logic io, input logic [7:0] e);
    @(posedge clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    reg_io_space_in <= io;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 `CHK("reg_rdata_out", e, reg_rdata_out)
  endtask

  // Bounded wait for the timed operation to end.
  task automatic wait_idle();
    int i;
    i = 0;
    while (flash_busy_out !== 1'b0 && i < 200) begin
      @(posedge clk_in);
      #1 i++;
    end
    if (flash_busy_out !== 1'b0) begin
      miscompares++;
      stop_test();
    end
  endtask

  task automatic stop_test();
    if (miscompares == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence; each operation waits out its window before the next one.
  initial begin
    {reset_in, reg_io_space_in, reg_wr_in, reg_rd_in, global_int_in} = 5'b10001;
    {reg_addr_in, reg_wdata_in, flash_rd_index_in} = 23'h0;
    boot_size_fuse_in = 2'b11;
    for (int f = 3; f >= 0; f--) begin
      @(posedge clk_in);
      reset_in <= 1'b1;
      boot_size_fuse_in <= f[1:0];
      repeat (4) @(posedge clk_in);
      reset_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      #1 `CHK("boot_start_out", boot_exp[f], boot_start_out)
    end
    check_csr(8'h57, 1'b0, 8'h00);
    reg_wr(8'h80);
    #1 `CHK("irq_out", 1'b1, irq_out)
    @(posedge clk_in);
    global_int_in <= 1'b0;
    @(posedge clk_in);
    #1 `CHK("irq_out", 1'b0, irq_out)
    @(posedge clk_in);
    global_int_in <= 1'b1;
    check_csr(8'h37, 1'b1, 8'h80);
    check_csr(8'h57, 1'b1, 8'h00);
    reg_wr(8'h87);
    check_csr(8'h57, 1'b0, 8'h80);
    reg_wr(8'h81);
    #1 `CHK("irq_out", 1'b0, irq_out)
    repeat (5) @(posedge clk_in);
    check_csr(8'h57, 1'b0, 8'h80);
    reg_wr(8'h01);
    cpu.spm(16'h0007, 16'h1234);
    flash_rd_index_in <= 7'h03;
    @(posedge clk_in);
    #1 `CHK("flash_rd_word_out", 16'h1234, flash_rd_word_out)
    check_csr(8'h57, 1'b0, 8'h00);
    reg_wr(8'h11);
    repeat (5) @(posedge clk_in);
    #1 `CHK("flash_rd_word_out", 16'hFFFF, flash_rd_word_out)
    reg_wr(8'h03);
    cpu.spm(16'h1000, 16'h5A5A);
    #1 `CHK("flash_erase_out", 1'b1, flash_erase_out)
    `CHK("page_select_field_out", 8'h10, page_select_field_out)
    `CHK("rww_read_block_out", 1'b1, rww_read_block_out)
    `CHK("cpu_stall_out", 1'b0, cpu_stall_out)
    `CHK("flash_busy_out", 1'b1, flash_busy_out)
    check_csr(8'h57, 1'b0, 8'h43);
    wait_idle();
    check_csr(8'h57, 1'b0, 8'h40);
    reg_wr(8'h11);
    cpu.spm(16'h0000, 16'h0000);
    check_csr(8'h57, 1'b0, 8'h00);
    reg_wr(8'h05);
    cpu.spm(16'h7000, 16'h0000);
    #1 `CHK("flash_write_out", 1'b1, flash_write_out)
    `CHK("cpu_stall_out", 1'b1, cpu_stall_out)
    `CHK("rww_read_block_out", 1'b0, rww_read_block_out)
    wait_idle();
    check_csr(8'h57, 1'b0, 8'h00);
    reg_wr(8'h09);
    cpu.spm(16'h1234, 16'hAA3C);
    #1 `CHK("flash_lock_write_out", 1'b1, flash_lock_write_out)
    `CHK("lock_data_out", 8'h3C, lock_data_out)
    wait_idle();
    for (int p = 0; p < 4; p++) begin
      reg_wr(8'h09);
      cpu.lpm(p[15:0]);
      #1 `CHK("load_data_out", rd_exp[p], load_data_out)
      `CHK("load_taken_out", 1'b1, load_taken_out)
      repeat (4) @(posedge clk_in);
    end
    reg_wr(8'h21);
    cpu.spm(16'h0006, 16'h0000);
    #1 `CHK("flash pulses", 3'b000, {flash_erase_out, flash_write_out, flash_lock_write_out})
    @(posedge clk_in);
    #1 `CHK("flash_rd_word_out", 16'hFFFF, flash_rd_word_out)
    check_csr(8'h57, 1'b0, 8'h00);
    reg_wr(8'h21);
    cpu.lpm(16'h0002);
    #1 `CHK("load_data_out", SIG, load_data_out)
    check_csr(8'h57, 1'b0, 8'h00);
    stop_test();
  end
endmodule
`default_nettype wire
